// ---- dv/testbench.sv ----
// Self-checking bench for the two-wire converter control block
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("mismatch %s expected %h seen %h", what, exp, got); \
      end \
   end

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, resetn, wbCyc, wbStb, wbWe, wbAck, scl, sdaOeM, sdaOe, addrSelPin, a;
   logic bufferEnable, termLowEn, termHighEn;
   logic [3:0] wbAdr, wbSel;
   logic [31:0] wbDatI, wbDatO, expV;
   logic [31:0] expQ[$];
   logic [9:0] converterCode, dacV, inV;
   logic [1:0] powerMode;
   logic [15:0] rnd;
   logic [7:0] b1, b2;
   logic [6:0] me;
   logic sdaOut;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   // Pull-up wins unless a party pulls low
   // Device puts its data value on the line only while enabled
   wire sdaWire = ~sdaOeM & (sdaOe ? sdaOut : 1'b1);

   dac_two_wire_slave DUT (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelPin(addrSelPin),
      .converterCode(converterCode), .powerMode(powerMode), .bufferEnable(bufferEnable),
      .termLowEn(termLowEn), .termHighEn(termHighEn));
   two_wire_master MST (.scl(scl), .sdaOeM(sdaOeM), .sdaWire(sdaWire));

   always #50 clk_sys = ~clk_sys;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic conclude();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         $display("mismatch timeout expected done seen running");
         conclude();
      end
   end

   // Read data checked against the oldest note at the acknowledge edge
   always @(posedge clk_sys)
      if (wbAck === 1'b1 && wbWe === 1'b0)
      begin
         expV = (expQ.size() > 0) ? expQ.pop_front() : 32'hDEAD_BEEF;
         `CHK("wb read data", expV, wbDatO)
      end

   task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int k;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbSel <= 4'hF;
      wbAdr <= adr;
      wbDatI <= dat;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (wbAck !== 1'b1 && k < 50);
      `CHK("wb ack", 1'b1, wbAck)
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wbXfer

   task automatic wbRd(input logic [3:0] adr, input logic [31:0] exp);
      expQ.push_back(exp);
      wbXfer(1'b0, adr, 32'h0000_0000);
   endtask : wbRd

   // Off-edge phase keeps link events away from the sampling edge
   task automatic frame(input logic [6:0] adr, input logic rw, input logic expAck);
      @(posedge clk_sys);
      #37;
      MST.start();
      MST.wrByte({adr, rw}, a);
      `CHK("address ack", expAck, a)
   endtask : frame

   task automatic pair(input logic [3:0] cmd, input logic [9:0] code);
      MST.wrByte({cmd, code[9:6]}, a);
      `CHK("command ack", 1'b1, a)
      MST.wrByte({code[5:0], 2'h0}, a);
      `CHK("data ack", 1'b1, a)
   endtask : pair

   task automatic chkOut(input logic [9:0] code, input logic [1:0] mode);
      `CHK("converter code", code, converterCode)
      `CHK("power mode", mode, powerMode)
      `CHK("buffer enable", mode == dac_pkg::PWR_UP, bufferEnable)
      `CHK("low termination", mode == dac_pkg::PWR_TERM_LOW, termLowEn)
      `CHK("high termination", mode == dac_pkg::PWR_TERM_HIGH, termHighEn)
   endtask : chkOut

   initial
   begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 4'h0;
      wbSel = 4'hF;
      wbDatI = 32'h0000_0000;
      addrSelPin = 1'b0;
      rnd = 16'h0003;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chkOut(10'h000, dac_pkg::MODE_RESET);
      wbRd(dac_pkg::REG_CTRL, 32'h0000_0001);
      wbXfer(1'b1, 4'hC, 32'hFFFF_FFFF);
      wbRd(4'hC, 32'h0000_0000);
      for (int p = 0; p < 2; p++)
      begin
         @(posedge clk_sys);
         addrSelPin <= p[0];
         me = {dac_pkg::ADDR_HIGH, p[0]};
         frame(me ^ 7'h01, 1'b0, 1'b0);
         MST.wrByte(8'hC0, a);
         `CHK("ignored byte ack", 1'b0, a)
         MST.stop();
         frame(me, 1'b0, 1'b1);
         MST.stop();
         wbRd(dac_pkg::REG_STATUS, {23'h0, p[0], 6'h0, dac_pkg::MODE_RESET});
      end
      rnd = lfsr(rnd);
      dacV = rnd[9:0];
      inV = dacV;
      frame(me, 1'b0, 1'b1);
      pair(4'h4, 10'h000);
      pair(dac_pkg::CMD_LOAD_BOTH, dacV);
      MST.stop();
      chkOut(dacV, dac_pkg::PWR_UP);
      for (int m = 1; m < 5; m++)
      begin
         rnd = lfsr(rnd);
         frame(me, 1'b0, 1'b1);
         pair({2'h1, rnd[1:0]}, {m[1:0], rnd[9:2]});
         MST.stop();
         chkOut(dacV, m[1:0]);
      end
      rnd = lfsr(rnd);
      frame(me, 1'b0, 1'b1);
      pair(dac_pkg::CMD_LOAD_IN, rnd[9:0]);
      MST.stop();
      inV = rnd[9:0];
      chkOut(dacV, dac_pkg::PWR_UP);
      wbRd(dac_pkg::REG_CODES, {6'h0, inV, 6'h0, dacV});
      rnd = lfsr(rnd);
      frame(me, 1'b0, 1'b1);
      pair(dac_pkg::CMD_LOAD_SWAP, rnd[9:0]);
      MST.stop();
      dacV = inV;
      inV = rnd[9:0];
      chkOut(dacV, dac_pkg::PWR_UP);
      frame(me, 1'b0, 1'b1);
      pair(dac_pkg::CMD_COPY, ~inV);
      MST.stop();
      dacV = inV;
      chkOut(dacV, dac_pkg::PWR_UP);
      rnd = lfsr(rnd);
      frame(me, 1'b0, 1'b1);
      MST.wrByte({dac_pkg::CMD_LOAD_BOTH, rnd[9:6]}, a);
      MST.stop();
      frame(me, 1'b0, 1'b1);
      MST.wrByte({dac_pkg::CMD_LOAD_BOTH, rnd[3:0]}, a);
      frame(me, 1'b0, 1'b1);
      pair(dac_pkg::CMD_LOAD_IN, rnd[9:0]);
      inV = rnd[9:0];
      pair(4'h8, 10'h000);
      frame(me, 1'b1, 1'b1);
      MST.rdByte(1'b1, b1);
      MST.rdByte(1'b0, b2);
      MST.stop();
      `CHK("read high byte", {4'h0, dacV[9:6]}, b1)
      `CHK("read low byte", {dacV[5:0], 2'h0}, b2)
      chkOut(dacV, dac_pkg::PWR_UP);
      wbRd(dac_pkg::REG_CODES, {6'h0, inV, 6'h0, dacV});
      @(posedge clk_sys);
      #37;
      MST.startStop();
      wbRd(dac_pkg::REG_STATUS, 32'h0000_0110);
      frame(me, 1'b0, 1'b1);
      MST.stop();
      wbXfer(1'b1, dac_pkg::REG_CTRL, 32'h0000_0000);
      frame(me, 1'b0, 1'b0);
      MST.stop();
      wbXfer(1'b1, dac_pkg::REG_CTRL, 32'h0000_0001);
      frame(me, 1'b0, 1'b1);
      MST.stop();
      `CHK("data stable while clock high", 0, MST.nBad)
      conclude();
   end
endmodule : testbench

// ---- dv/two_wire_master.sv ----
// Behavioural two-wire bus master for the converter control bench
module two_wire_master (
   // Link clock and data pull-down from the master
   output logic scl,
   output logic sdaOeM,
   // Resolved data line
   input wire logic sdaWire
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int Q = 200;
   int nBad = 0;

   // Clock stands high between frames and only the master moves it
   initial
   begin
      scl = 1'b1;
      sdaOeM = 1'b0;
   end

   // Data moves only while the clock is low; the device must hold it while high
   task automatic bitIo(input logic b, output logic r);
      #Q sdaOeM = ~b;
      #Q scl = 1'b1;
      #(Q / 2) r = sdaWire;
      #Q if (sdaWire !== r) nBad++;
      #(Q / 2) scl = 1'b0;
   endtask : bitIo

   // Works from idle and, with the clock low, as a repeated START
   task automatic start();
      if (scl === 1'b0)
      begin
         #Q sdaOeM = 1'b0;
         #Q scl = 1'b1;
      end
      #(2 * Q) sdaOeM = 1'b1;
      #(2 * Q) scl = 1'b0;
   endtask : start

   // Only called after at least one clock pulse of the frame
   task automatic stop();
      #Q sdaOeM = 1'b1;
      #Q scl = 1'b1;
      #(2 * Q) sdaOeM = 1'b0;
      #(2 * Q);
   endtask : stop

   // START and STOP in one high pulse, from idle; the STOP must be ignored
   task automatic startStop();
      #(2 * Q) sdaOeM = 1'b1;
      #(2 * Q) sdaOeM = 1'b0;
      #(2 * Q);
   endtask : startStop

   // Eight bits first MSB, then the acknowledge slot
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitIo(d[i], r);
      bitIo(1'b1, r);
      ack = ~r;
   endtask : wrByte

   // Last byte of a read is refused before the STOP
   task automatic rdByte(input logic ackIt, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitIo(1'b1, r);
         d[i] = r;
      end
      bitIo(~ackIt, r);
   endtask : rdByte
endmodule : two_wire_master

// ---- rtl/dac_pkg.sv ----
// Shared constants and types for the two-wire converter control block
// Behaviour
// - Address LSB follows address-select pin level.
// - Data goes to converter or input register.
// - Both registers hold while power stays applied.
// - Code is unsigned 10-bit straight binary.
// - Reset clears registers, powers down, high termination.
// - Three power-down modes: float, low, high.
// - Two mode bits: 00 up, then modes 1-3.
// - Power-down keeps data; wake restores old code.
// - Slave only; never drives clock or starts.
// - START/STOP framing; eight bits plus acknowledge.
// - Data stable while clock high; changes are conditions.
// - START is data fall, STOP rise, clock high.
// - After STOP or mismatch, ignore clock until START.
// - STOP honoured anywhere except START's own high pulse.
// - Back-to-back writes allowed; reads need repeated START.
// - Acknowledge received bytes by holding data low.
// - Release data in ninth clock, sample master acknowledge.
// - Idle waits START, compares address bit by bit.
// - Eighth address bit: zero write, one read.
// - Four-bit command field selects register action.
// - Update at acknowledge falling edge; aborted writes ignored.
package dac_pkg;

   // Preset upper slave address bits, value arbitrary
   localparam logic [5:0] ADDR_HIGH = 6'h08;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Command field values
   localparam logic [3:0] CMD_LOAD_BOTH = 4'hC;
   localparam logic [3:0] CMD_LOAD_IN = 4'hD;
   localparam logic [3:0] CMD_LOAD_SWAP = 4'hE;
   localparam logic [3:0] CMD_COPY = 4'hF;
   localparam logic [1:0] CMD_POWER_PFX = 2'h1;

   // Power mode bits
   localparam logic [1:0] PWR_UP = 2'h0;
   localparam logic [1:0] PWR_FLOAT = 2'h1;
   localparam logic [1:0] PWR_TERM_LOW = 2'h2;
   localparam logic [1:0] PWR_TERM_HIGH = 2'h3;

   // Reset values
   localparam logic [1:0] MODE_RESET = PWR_TERM_HIGH;
   localparam logic [9:0] CODE_RESET = 10'h000;
   localparam logic [2:0] SYNC_RESET = 3'h3;
   localparam logic CTRL_RESET = 1'b1;

   // Register offsets and field positions
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CODES = 4'h8;
   localparam int CTRL_EN_POS = 0;
   localparam int STAT_MODE_POS = 0;
   localparam int STAT_BUSY_POS = 4;
   localparam int STAT_LSB_POS = 8;
   localparam int CODES_DAC_POS = 0;
   localparam int CODES_IN_POS = 16;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_TX} link_state_t;

endpackage : dac_pkg

// ---- rtl/dac_two_wire_slave.sv ----
// Two-wire slave, data registers and power mode control of the converter
module dac_two_wire_slave (
   // System
   input wire logic clk_sys,
   input wire logic resetn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Two-wire pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic addrSelPin,
   // Converter side
   output logic [9:0] converterCode,
   output logic [1:0] powerMode,
   output logic bufferEnable,
   output logic termLowEn,
   output logic termHighEn
);

   logic [2:0] syncd;
   logic sclS, sdaS, addrLsbS;
   logic sclPrev_ff, sdaPrev_ff, startSeen_ff;
   logic sclRise, sclFall, startCond, stopCond, stopOk;
   dac_pkg::link_state_t state_ff;
   logic [3:0] bitCnt_ff;
   logic [7:0] shift_ff, cmdByte_ff;
   logic [6:0] addrCmp_ff;
   logic ackSlot_ff, masterAck_ff, txSecond_ff, sdaOe_ff, sdaOut_ff;
   logic [9:0] inputReg_ff, dacReg_ff;
   logic [1:0] mode_ff;
   logic bufEn_ff, termLow_ff, termHigh_ff;
   logic ctrlEn_ff, wbAck_ff;
   logic [31:0] wbDat_ff;
   logic commit;
   logic [3:0] cmd;
   logic [9:0] codeRx;
   logic [7:0] txFirst, txNext;

   // Read-back byte: first carries D9-D6, second D5-D0 padded
   function automatic logic [7:0] txByte(input logic second, input logic [9:0] code);
      txByte = second ? {code[5:0], 2'b00} : {4'h0, code[9:6]};
   endfunction : txByte

   function automatic logic [31:0] regRead(input logic [3:0] adr);
      regRead = 32'h0000_0000;
      unique case (adr)
         dac_pkg::REG_CTRL:
            regRead[dac_pkg::CTRL_EN_POS] = ctrlEn_ff;
         dac_pkg::REG_STATUS:
         begin
            regRead[dac_pkg::STAT_MODE_POS +: 2] = mode_ff;
            regRead[dac_pkg::STAT_BUSY_POS] = (state_ff != dac_pkg::ST_IDLE);
            regRead[dac_pkg::STAT_LSB_POS] = addrLsbS;
         end
         dac_pkg::REG_CODES:
         begin
            regRead[dac_pkg::CODES_DAC_POS +: 10] = dacReg_ff;
            regRead[dac_pkg::CODES_IN_POS +: 10] = inputReg_ff;
         end
         default:
            regRead = 32'h0000_0000;
      endcase
   endfunction : regRead

   // Pins pass two flops before any decoding
   sync_two_flop u_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .asyncIn({addrSelPin, sdaIn, scl}),
      .syncOut(syncd)
   );

   assign sclS = syncd[0];
   assign sdaS = syncd[1];
   assign addrLsbS = syncd[2];
   assign txFirst = txByte(1'b0, dacReg_ff);
   assign txNext = txByte(1'b1, dacReg_ff);

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
      end
      else
      begin
         sclPrev_ff <= sclS;
         sdaPrev_ff <= sdaS;
      end
   end

   assign sclRise = sclS && !sclPrev_ff;
   assign sclFall = !sclS && sclPrev_ff;
   // Conditions are data edges while clock stays high
   assign startCond = sclS && sclPrev_ff && sdaPrev_ff && !sdaS;
   assign stopCond = sclS && sclPrev_ff && !sdaPrev_ff && sdaS;
   // STOP in the START's own high pulse is not legal framing
   assign stopOk = stopCond && !startSeen_ff;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         startSeen_ff <= 1'b0;
      else if (startCond)
         startSeen_ff <= 1'b1;
      else if (sclFall)
         startSeen_ff <= 1'b0;
   end

   // Link state machine; the clock is only ever sampled
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff <= dac_pkg::ST_IDLE;
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         cmdByte_ff <= 8'h00;
         addrCmp_ff <= 7'h00;
         ackSlot_ff <= 1'b0;
         masterAck_ff <= 1'b0;
         txSecond_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
      end
      else if (startCond && ctrlEn_ff)
      begin
         // START or repeated START reframes whenever the control enable is set
         state_ff <= dac_pkg::ST_ADDR;
         bitCnt_ff <= 4'h0;
         ackSlot_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
         addrCmp_ff <= {dac_pkg::ADDR_HIGH, addrLsbS};
      end
      else if (stopOk)
      begin
         // Aborted writes never reach the commit point
         state_ff <= dac_pkg::ST_IDLE;
         ackSlot_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
      end
      else if (state_ff != dac_pkg::ST_IDLE)
      begin
         if (sclRise)
         begin
            if (ackSlot_ff)
               masterAck_ff <= !sdaS;
            else
            begin
               bitCnt_ff <= bitCnt_ff + 4'h1;
               if (state_ff != dac_pkg::ST_TX)
                  shift_ff <= {shift_ff[6:0], sdaS};
               if (state_ff == dac_pkg::ST_ADDR && bitCnt_ff < 4'h7)
               begin
                  addrCmp_ff <= {addrCmp_ff[5:0], 1'b0};
                  // Drop out at the first wrong bit
                  if (sdaS != addrCmp_ff[6])
                     state_ff <= dac_pkg::ST_IDLE;
               end
            end
         end
         else if (sclFall)
         begin
            if (ackSlot_ff)
            begin
               ackSlot_ff <= 1'b0;
               sdaOe_ff <= 1'b0;
               bitCnt_ff <= 4'h0;
               unique case (state_ff)
                  dac_pkg::ST_ADDR:
                     // Last address bit gives direction
                     if (shift_ff[0])
                     begin
                        state_ff <= dac_pkg::ST_TX;
                        txSecond_ff <= 1'b0;
                        shift_ff <= txFirst;
                        sdaOe_ff <= !txFirst[7];
                     end
                     else
                        state_ff <= dac_pkg::ST_CMD;
                  dac_pkg::ST_CMD:
                  begin
                     state_ff <= dac_pkg::ST_DATA;
                     cmdByte_ff <= shift_ff;
                  end
                  dac_pkg::ST_DATA:
                     state_ff <= dac_pkg::ST_CMD;
                  dac_pkg::ST_TX:
                     // Second byte only after the first is acknowledged
                     if (masterAck_ff && !txSecond_ff)
                     begin
                        txSecond_ff <= 1'b1;
                        shift_ff <= txNext;
                        sdaOe_ff <= !txNext[7];
                     end
                     else
                        state_ff <= dac_pkg::ST_IDLE;
                  dac_pkg::ST_IDLE:
                     state_ff <= dac_pkg::ST_IDLE;
               endcase
            end
            else if (bitCnt_ff == dac_pkg::BYTE_BITS)
            begin
               // Ninth clock: pull low when receiving, release when sending
               ackSlot_ff <= 1'b1;
               sdaOe_ff <= (state_ff != dac_pkg::ST_TX);
            end
            else if (state_ff == dac_pkg::ST_TX)
            begin
               sdaOe_ff <= !shift_ff[6];
               shift_ff <= {shift_ff[6:0], 1'b0};
            end
         end
      end
   end

   // Open drain: only ever pulls low
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         sdaOut_ff <= 1'b0;
      else
         sdaOut_ff <= 1'b0;
   end

   assign cmd = cmdByte_ff[7:4];
   assign codeRx = {cmdByte_ff[3:0], shift_ff[7:2]};
   // Commit at the falling clock that ends the data acknowledge
   assign commit = (state_ff == dac_pkg::ST_DATA) && ackSlot_ff && sclFall && !startCond && !stopOk;

   // Data registers; plain flops keep contents while powered
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         inputReg_ff <= dac_pkg::CODE_RESET;
         dacReg_ff <= dac_pkg::CODE_RESET;
      end
      else if (commit)
      begin
         unique case (cmd)
            dac_pkg::CMD_LOAD_BOTH:
            begin
               inputReg_ff <= codeRx;
               dacReg_ff <= codeRx;
            end
            dac_pkg::CMD_LOAD_IN:
               inputReg_ff <= codeRx;
            dac_pkg::CMD_LOAD_SWAP:
            begin
               inputReg_ff <= codeRx;
               dacReg_ff <= inputReg_ff;
            end
            dac_pkg::CMD_COPY:
               dacReg_ff <= inputReg_ff;
            default:
               dacReg_ff <= dacReg_ff;
         endcase
      end
   end

   // Power mode; codes untouched so wake restores output
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         mode_ff <= dac_pkg::MODE_RESET;
      else if (commit && cmd[3:2] == dac_pkg::CMD_POWER_PFX)
         mode_ff <= cmdByte_ff[3:2];
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         bufEn_ff <= 1'b0;
         termLow_ff <= 1'b0;
         termHigh_ff <= 1'b1;
      end
      else
      begin
         // Any down mode turns buffer off; float selects neither
         bufEn_ff <= (mode_ff == dac_pkg::PWR_UP);
         termLow_ff <= (mode_ff == dac_pkg::PWR_TERM_LOW);
         termHigh_ff <= (mode_ff == dac_pkg::PWR_TERM_HIGH);
      end
   end

   // Wishbone: one wait state, unmapped reads return zero
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         wbAck_ff <= 1'b0;
         wbDat_ff <= 32'h0000_0000;
         ctrlEn_ff <= dac_pkg::CTRL_RESET;
      end
      else
      begin
         wbAck_ff <= wb_cyc_i && wb_stb_i && !wbAck_ff;
         if (wb_cyc_i && wb_stb_i && !wbAck_ff)
         begin
            wbDat_ff <= wb_we_i ? 32'h0000_0000 : regRead(wb_adr_i);
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == dac_pkg::REG_CTRL)
               ctrlEn_ff <= wb_dat_i[dac_pkg::CTRL_EN_POS];
         end
      end
   end

   assign wb_ack_o = wbAck_ff;
   assign wb_dat_o = wbDat_ff;
   assign sdaOe = sdaOe_ff;
   assign sdaOut = sdaOut_ff;
   assign converterCode = dacReg_ff;
   assign powerMode = mode_ff;
   assign bufferEnable = bufEn_ff;
   assign termLowEn = termLow_ff;
   assign termHighEn = termHigh_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_first_acked;
      ackSlot_ff && state_ff == dac_pkg::ST_TX && !txSecond_ff && masterAck_ff && sclFall && !startCond;
   endsequence

   property p_addr_lsb;
      startCond && ctrlEn_ff |=> addrCmp_ff[0] == $past(addrLsbS);
   endproperty
   a_addr_lsb: assert property (p_addr_lsb) else $error("address LSB not taken from pin");

   property p_input_only;
      commit && cmd == dac_pkg::CMD_LOAD_IN |=> converterCode == $past(converterCode);
   endproperty
   a_input_only: assert property (p_input_only) else $error("input-only load moved output");

   property p_load_both;
      commit && cmd == dac_pkg::CMD_LOAD_BOTH |=> converterCode == $past(codeRx) && inputReg_ff == $past(codeRx);
   endproperty
   a_load_both: assert property (p_load_both) else $error("load both failed");

   property p_no_commit;
      !commit |=> $stable(dacReg_ff) && $stable(inputReg_ff) && $stable(mode_ff);
   endproperty
   a_no_commit: assert property (p_no_commit) else $error("register changed outside commit");

   property p_mode_out;
      1'b1 |=> bufferEnable == ($past(mode_ff) == dac_pkg::PWR_UP)
         && termHighEn == ($past(mode_ff) == dac_pkg::PWR_TERM_HIGH);
   endproperty
   a_mode_out: assert property (p_mode_out) else $error("mode outputs wrong");

   property p_idle_quiet;
      state_ff == dac_pkg::ST_IDLE |-> !sdaOe_ff;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("driving data while idle");

   property p_start_stop_pulse;
      stopCond && startSeen_ff && !startCond |=> state_ff == $past(state_ff);
   endproperty
   a_start_stop_pulse: assert property (p_start_stop_pulse) else $error("stop in start pulse acted");

   property p_start;
      startCond && ctrlEn_ff |=> state_ff == dac_pkg::ST_ADDR && bitCnt_ff == 4'h0;
   endproperty
   a_start: assert property (p_start) else $error("start not framed");

   property p_ack_drive;
      ackSlot_ff && state_ff != dac_pkg::ST_TX && state_ff != dac_pkg::ST_IDLE |-> sdaOe_ff;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("receive acknowledge not driven");

   property p_tx_release;
      ackSlot_ff && state_ff == dac_pkg::ST_TX |-> !sdaOe_ff;
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("data not released for master ack");

   property p_second_byte;
      s_first_acked |=> txSecond_ff && state_ff == dac_pkg::ST_TX ##1 state_ff == dac_pkg::ST_TX;
   endproperty
   a_second_byte: assert property (p_second_byte) else $error("second byte not sent");

endmodule : dac_two_wire_slave

// ---- rtl/sync_two_flop.sv ----
// Two-flop synchroniser for the serial pins and address strap
module sync_two_flop (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Pins in, synchronised levels out
   input wire logic [2:0] asyncIn,
   output logic [2:0] syncOut
);

   logic [2:0] meta_ff;
   logic [2:0] sync_ff;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_ff <= dac_pkg::SYNC_RESET;
         sync_ff <= dac_pkg::SYNC_RESET;
      end
      else
      begin
         meta_ff <= asyncIn;
         sync_ff <= meta_ff;
      end
   end

   assign syncOut = sync_ff;

endmodule : sync_two_flop
